// ==== design/sier_pin_if.sv ====
// Carrier between the top and the pin synchroniser
`timescale 1ns/1ps
interface sier_pin_if;
    logic [sier_pkg::NCH-1:0] scl_raw;
    logic [sier_pkg::NCH-1:0] sda_raw;
    logic [sier_pkg::NCH-1:0] scl_sync;
    logic [sier_pkg::NCH-1:0] sda_sync;

    modport sync (input scl_raw, input sda_raw, output scl_sync, output sda_sync);
    modport user (output scl_raw, output sda_raw, input scl_sync, input sda_sync);
endinterface

// ==== design/sier_pin_sync.sv ====
// Two-stage synchroniser for the bus line inputs
`timescale 1ns/1ps
module sier_pin_sync (
    input  wire logic      i_core_clk,
    input  wire logic      i_rst,
    sier_pin_if.sync       pins
);
    logic [sier_pkg::NCH-1:0] scl_s1_r;
    logic [sier_pkg::NCH-1:0] sda_s1_r;
    logic [sier_pkg::NCH-1:0] scl_s2_r;
    logic [sier_pkg::NCH-1:0] sda_s2_r;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_s1_r <= '1;
            sda_s1_r <= '1;
            scl_s2_r <= '1;
            sda_s2_r <= '1;
        end else begin
            scl_s1_r <= pins.scl_raw;
            sda_s1_r <= pins.sda_raw;
            scl_s2_r <= scl_s1_r;
            sda_s2_r <= sda_s1_r;
        end
    end

    assign pins.scl_sync = scl_s2_r;
    assign pins.sda_sync = sda_s2_r;
endmodule

// ==== design/sier_pkg.sv ====
// Shared constants and types for the simplified I2C error-recovery channels
package sier_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int UNITS  = 2;
    localparam int CHANS  = 4;
    localparam int NCH    = UNITS * CHANS;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int HALF_BIT_NS   = 5000;
    // Least SCL half period, rounded up to whole cycles
    localparam int HALF_BIT_CYC  = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W         = 8;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_BIT_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Frame
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    localparam logic [7:0] RX_IDLE   = 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    // Channel status layout
    localparam int ST_W    = 8;
    localparam int ST_OVR  = 0;
    localparam int ST_ACK  = 1;
    localparam int ST_BFF  = 5;
    localparam int ST_BUSY = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [7:0] EN_RST    = 8'h00;
    localparam logic       LINE_RST  = 1'b1;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_LOW,
        CH_HIGH
    } sier_phase_t;

endpackage

// ==== design/sier_top.sv ====
// Two units of four simplified I2C master channels with error flags and stop/start control
`timescale 1ns/1ps

// Notes on behaviour
// - Two units, four channels each, every channel with own flags and control.
// - Reading a channel's data clears its buffer-full bit, allowing next byte.
// - Writing 1 in a flag-clear bit clears that channel error flag.
// - Writing 1 to a stop bit, with no start bit for that channel in the same write, clears enable status and halts the channel.
// - Writing 1 to a start bit sets enable status and lets the channel run.
// - A missing acknowledge means the bus is released by stop before resuming.
// - A stopped channel hands clock and data line latches to software.
module sier_top (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_unit_sel,
    input  wire logic [1:0]               i_chan_sel,
    input  wire logic                     i_data_wr,
    input  wire logic [7:0]               i_wdata,
    input  wire logic                     i_data_rd,
    input  wire logic                     i_clr_wr,
    input  wire logic [7:0]               i_clr_mask,
    input  wire logic                     i_start_wr,
    input  wire logic                     i_stop_wr,
    input  wire logic [3:0]               i_chan_mask,
    input  wire logic                     i_latch_wr,
    input  wire logic [3:0]               i_cko,
    input  wire logic [3:0]               i_so,
    input  wire logic [7:0]               i_rx_mode,
    input  wire logic [7:0]               i_out_en,
    input  wire logic [7:0]               i_scl_in,
    input  wire logic [7:0]               i_sda_in,
    output logic      [7:0]               o_rdata,
    output logic      [7:0]               o_status,
    output logic      [7:0]               o_enable_status,
    output logic      [7:0]               o_scl_o,
    output logic      [7:0]               o_scl_oe_n,
    output logic      [7:0]               o_sda_o,
    output logic      [7:0]               o_sda_oe_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Spread a four-channel mask onto the selected unit
    function automatic logic [7:0] unit_mask(input logic unit, input logic [3:0] mask);
        unit_mask = unit ? {mask, 4'h0} : {4'h0, mask};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    sier_pin_if pif ();

    assign pif.scl_raw = i_scl_in;
    assign pif.sda_raw = i_sda_in;

    sier_pin_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .pins       (pif.sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bit-rate divider

    logic [sier_pkg::DIV_W-1:0] div_r;
    logic                       tick_r;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r  <= (div_r == sier_pkg::DIV_LAST) ? '0 : div_r + 1'b1;
            tick_r <= (div_r == sier_pkg::DIV_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel selection and unit strobes

    wire [2:0] sel_idx    = {i_unit_sel, i_chan_sel};
    wire [7:0] sel_onehot = 8'h01 << sel_idx;
    wire [7:0] start_hit  = i_start_wr ? unit_mask(i_unit_sel, i_chan_mask) : 8'h00;
    wire [7:0] stop_hit   = i_stop_wr ? unit_mask(i_unit_sel, i_chan_mask) : 8'h00;
    wire [7:0] latch_hit  = i_latch_wr ? unit_mask(i_unit_sel, 4'hf) : 8'h00;
    wire [7:0] cko_all    = {i_cko, i_cko};
    wire [7:0] so_all     = {i_so, i_so};

    ////////////////////////////////////////////////////////////////////////////
    // Enable status

    logic [7:0] en_r;
    wire  [7:0] en_nxt = (en_r & ~stop_hit) | start_hit;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            en_r <= sier_pkg::EN_RST;
        end else begin
            en_r <= en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels

    logic [7:0] chan_rdata  [sier_pkg::NCH];
    logic [7:0] chan_status [sier_pkg::NCH];
    logic [7:0] scl_lvl;
    logic [7:0] sda_lvl;

    genvar g;
    generate
        for (g = 0; g < sier_pkg::NCH; g++) begin : g_ch
            sier_pkg::sier_phase_t state_r;
            logic [3:0]            bit_r;
            logic [7:0]            shift_r;
            logic [7:0]            rdata_r;
            logic                  bff_r;
            logic                  ovr_r;
            logic                  ack_r;
            logic                  scl_r;
            logic                  sda_r;

            wire sda_s     = pif.sda_sync[g];
            wire scl_s     = pif.scl_sync[g];
            wire rx        = i_rx_mode[g];
            wire my_sel    = sel_onehot[g];
            wire data_rd   = i_data_rd && my_sel;
            wire clr_wr    = i_clr_wr && my_sel;
            wire start_x   = en_r[g] && i_data_wr && my_sel && (state_r == sier_pkg::CH_IDLE);
            // Clock stretching: the high half waits for the line to read high
            wire sample    = (state_r == sier_pkg::CH_HIGH) && tick_r && scl_s;
            wire data_smp  = sample && (bit_r <= sier_pkg::BIT_LAST);
            wire frame_end = sample && (bit_r == sier_pkg::BIT_ACK);
            wire rx_byte   = data_smp && rx && (bit_r == sier_pkg::BIT_LAST);
            wire tx_nack   = frame_end && !rx && sda_s;
            wire ack_out   = rx ? !i_out_en[g] : 1'b1;
            wire [7:0] shift_nxt = {shift_r[6:0], sda_s};
            wire [7:0] load_val  = rx ? sier_pkg::RX_IDLE : i_wdata;
            wire next_bit  = (bit_r == sier_pkg::BIT_LAST) ? ack_out : shift_nxt[7];

            // Byte engine; a stopped channel aborts at once
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    state_r <= sier_pkg::CH_IDLE;
                    bit_r   <= sier_pkg::BIT_FIRST;
                    shift_r <= sier_pkg::DATA_RST;
                end else if (!en_r[g]) begin
                    state_r <= sier_pkg::CH_IDLE;
                end else begin
                    case (state_r)
                        sier_pkg::CH_IDLE: begin
                            if (start_x) begin
                                state_r <= sier_pkg::CH_LOW;
                                bit_r   <= sier_pkg::BIT_FIRST;
                                shift_r <= load_val;
                            end
                        end
                        sier_pkg::CH_LOW: begin
                            if (tick_r) begin
                                state_r <= sier_pkg::CH_HIGH;
                            end
                        end
                        sier_pkg::CH_HIGH: begin
                            if (frame_end) begin
                                state_r <= sier_pkg::CH_IDLE;
                            end else if (sample) begin
                                state_r <= sier_pkg::CH_LOW;
                                bit_r   <= bit_r + 1'b1;
                                shift_r <= shift_nxt;
                            end
                        end
                        default: begin
                            state_r <= sier_pkg::CH_IDLE;
                        end
                    endcase
                end
            end

            // Line drive: engine while enabled, software latches while stopped
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    scl_r <= sier_pkg::LINE_RST;
                    sda_r <= sier_pkg::LINE_RST;
                end else if (!en_r[g]) begin
                    if (latch_hit[g]) begin
                        scl_r <= cko_all[g];
                        sda_r <= so_all[g];
                    end
                end else if (start_x) begin
                    scl_r <= 1'b0;
                    sda_r <= load_val[7];
                end else if ((state_r == sier_pkg::CH_LOW) && tick_r) begin
                    scl_r <= 1'b1;
                end else if (sample) begin
                    scl_r <= 1'b0;
                    if (!frame_end) begin
                        sda_r <= next_bit;
                    end
                end
            end

            // Receive buffer and flags; a hardware set wins over a clear
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    rdata_r <= sier_pkg::DATA_RST;
                    bff_r   <= 1'b0;
                    ovr_r   <= 1'b0;
                    ack_r   <= 1'b0;
                end else begin
                    if (rx_byte) begin
                        rdata_r <= shift_nxt;
                    end
                    bff_r <= rx_byte ? 1'b1 : (data_rd ? 1'b0 : bff_r);
                    if (rx_byte && bff_r && !data_rd) begin
                        ovr_r <= 1'b1;
                    end else if (clr_wr && i_clr_mask[sier_pkg::ST_OVR]) begin
                        ovr_r <= 1'b0;
                    end
                    if (tx_nack) begin
                        ack_r <= 1'b1;
                    end else if (clr_wr && i_clr_mask[sier_pkg::ST_ACK]) begin
                        ack_r <= 1'b0;
                    end
                end
            end

            always_comb begin
                chan_status[g]                    = '0;
                chan_status[g][sier_pkg::ST_OVR]  = ovr_r;
                chan_status[g][sier_pkg::ST_ACK]  = ack_r;
                chan_status[g][sier_pkg::ST_BFF]  = bff_r;
                chan_status[g][sier_pkg::ST_BUSY] = (state_r != sier_pkg::CH_IDLE);
            end

            assign chan_rdata[g] = rdata_r;
            assign scl_lvl[g]    = scl_r;
            assign sda_lvl[g]    = sda_r;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata         <= sier_pkg::DATA_RST;
            o_status        <= '0;
            o_enable_status <= sier_pkg::EN_RST;
            o_scl_o         <= 8'h00;
            o_sda_o         <= 8'h00;
            o_scl_oe_n      <= 8'hff;
            o_sda_oe_n      <= 8'hff;
        end else begin
            if (i_data_rd) begin
                o_rdata <= chan_rdata[sel_idx];
            end
            o_status        <= chan_status[sel_idx];
            o_enable_status <= en_r;
            o_scl_o         <= 8'h00;
            o_sda_o         <= 8'h00;
            // Open drain: a low level pulls the line, a high level releases it
            o_scl_oe_n      <= scl_lvl;
            o_sda_oe_n      <= sda_lvl;
        end
    end

endmodule

// ==== tb/sier_slave_model.sv ====
// Behavioural I2C slave on one channel's open-drain lines
`timescale 1ns/1ps
module sier_slave_model (
    input  wire logic       i_scl,
    input  wire logic       i_clr,
    input  wire logic       i_ack,
    input  wire logic [7:0] i_byte,
    output logic            o_sda_n
);
    int   cnt;
    logic seen;
    always @(posedge i_scl or posedge i_clr) seen <= !i_clr;
    always @(negedge i_scl or posedge i_clr) begin
        if (i_clr) cnt <= 0;
        else if (seen) cnt <= cnt + 1;
    end
    // Data MSB first, then ack or nack, then release
    assign o_sda_n = (cnt < 8) ? i_byte[3'(7 - cnt)] : (cnt == 8) ? !i_ack : 1'b1;
endmodule

// ==== tb/sier_top_props.sv ====
// Port-level checks for the channel array
`timescale 1ns/1ps
module sier_top_props (
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    input wire logic       i_unit_sel,
    input wire logic [1:0] i_chan_sel,
    input wire logic       i_data_rd,
    input wire logic       i_clr_wr,
    input wire logic [7:0] i_clr_mask,
    input wire logic       i_start_wr,
    input wire logic       i_stop_wr,
    input wire logic [3:0] i_chan_mask,
    input wire logic       i_latch_wr,
    input wire logic [3:0] i_cko,
    input wire logic [3:0] i_so,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] o_status,
    input wire logic [7:0] o_enable_status,
    input wire logic [7:0] o_scl_o,
    input wire logic [7:0] o_scl_oe_n,
    input wire logic [7:0] o_sda_o,
    input wire logic [7:0] o_sda_oe_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////////
    wire  [7:0] sm  = i_unit_sel ? {i_chan_mask, 4'h0} : {4'h0, i_chan_mask};
    wire  [2:0] sel = {i_unit_sel, i_chan_sel};
    logic       cko_h;
    logic       so_h;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) {cko_h, so_h} <= 2'b11;
        else if (i_latch_wr && !i_unit_sel) {cko_h, so_h} <= {i_cko[0], i_so[0]};
    end
    ////////////////////////////////////////////////////////////////////////////
    a_start_sets: assert property (i_start_wr |-> ##2 ((o_enable_status & $past(sm, 2)) == $past(sm, 2)))
        else $error("start did not set enable bits");
    a_stop_clears: assert property ((i_stop_wr && !i_start_wr) |-> ##2 ((o_enable_status & $past(sm, 2)) == 8'h00))
        else $error("stop did not clear enable bits");
    a_enable_hold: assert property (!(i_start_wr || i_stop_wr) |-> ##2 $stable(o_enable_status))
        else $error("enable bits changed without strobe");
    a_rdata_hold: assert property (!i_data_rd |=> $stable(o_rdata))
        else $error("read data changed without read");
    a_read_clears: assert property ((i_data_rd && $stable(sel) && !o_status[sier_pkg::ST_BUSY]) ##1 $stable(sel) [*2]
        |-> !o_status[sier_pkg::ST_BFF]) else $error("read left buffer full set");
    a_clr_ack: assert property ((i_clr_wr && i_clr_mask[1] && $stable(sel) && !o_status[sier_pkg::ST_BUSY])
        ##1 $stable(sel) [*2] |-> !o_status[sier_pkg::ST_ACK]) else $error("ack error not cleared");
    a_clr_keep: assert property ((i_clr_wr && !i_clr_mask[1] && $stable(sel) && o_status[sier_pkg::ST_ACK])
        ##1 $stable(sel) [*2] |-> o_status[sier_pkg::ST_ACK]) else $error("unmasked ack error cleared");
    a_latch_take: assert property ((i_latch_wr && !i_unit_sel && !o_enable_status[0] && !i_start_wr
        && !$past(i_start_wr)) |=> ##[0:1] (o_scl_oe_n[0] == cko_h && o_sda_oe_n[0] == so_h))
        else $error("stopped channel ignored latch write");
    a_stop_quiet: assert property ((!o_enable_status[0] && !i_start_wr && !i_latch_wr && !$past(i_start_wr))
        ##1 !i_latch_wr |=> $stable(o_scl_oe_n[0]) && $stable(o_sda_oe_n[0])) else $error("stopped lines moved");
    a_outs_low: assert property (o_scl_o == 8'h00 && o_sda_o == 8'h00)
        else $error("line output value not low");
    c_start: cover property (i_start_wr);
    c_latch: cover property (i_latch_wr && !o_enable_status[0]);
    c_read: cover property (i_data_rd && o_status[sier_pkg::ST_BFF]);
    c_clr: cover property (i_clr_wr && o_status[sier_pkg::ST_ACK]);
endmodule

bind sier_top sier_top_props i_props (.i_core_clk, .i_rst, .i_unit_sel, .i_chan_sel, .i_data_rd, .i_clr_wr,
    .i_clr_mask, .i_start_wr, .i_stop_wr, .i_chan_mask, .i_latch_wr, .i_cko, .i_so, .o_rdata, .o_status,
    .o_enable_status, .o_scl_o, .o_scl_oe_n, .o_sda_o, .o_sda_oe_n);

// ==== tb/sier_top_tb.sv ====
// Self-checking bench for the channel array with one slave on channel 0
`timescale 1ns/1ps
module sier_top_tb;
    logic       i_core_clk, i_rst, i_unit_sel, i_data_wr, i_data_rd, i_clr_wr, i_start_wr, i_stop_wr, i_latch_wr;
    logic [1:0] i_chan_sel;
    logic [3:0] i_chan_mask, i_cko, i_so;
    logic [7:0] i_wdata, i_clr_mask, i_rx_mode, i_out_en, s_byte;
    logic       s_clr, s_ack;
    wire        s_sda_n;
    wire  [7:0] o_rdata, o_status, o_enable_status, o_scl_o, o_scl_oe_n, o_sda_o, o_sda_oe_n;
    // Pulled-up open-drain lines
    wire  [7:0] scl_w = o_scl_oe_n | o_scl_o;
    wire  [7:0] sda_w = (o_sda_oe_n | o_sda_o) & {7'h7f, s_sda_n};
    logic [8:0] cap;
    int         n_mismatch, total_checks;

    sier_top i_dut (.i_core_clk, .i_rst, .i_unit_sel, .i_chan_sel, .i_data_wr, .i_wdata, .i_data_rd, .i_clr_wr,
        .i_clr_mask, .i_start_wr, .i_stop_wr, .i_chan_mask, .i_latch_wr, .i_cko, .i_so, .i_rx_mode, .i_out_en,
        .i_scl_in(scl_w), .i_sda_in(sda_w), .o_rdata, .o_status, .o_enable_status, .o_scl_o, .o_scl_oe_n,
        .o_sda_o, .o_sda_oe_n);
    sier_slave_model i_slave (.i_scl(scl_w[0]), .i_clr(s_clr), .i_ack(s_ack), .i_byte(s_byte), .o_sda_n(s_sda_n));

    always @(posedge scl_w[0]) cap <= {cap[7:0], sda_w[0]};
    initial begin
        i_core_clk = 0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n = 1);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // 0 data write, 1 read, 2 clear, 3 start, 4 stop, 5 latch
    task automatic strobe(input int k);
        {i_data_wr, i_data_rd, i_clr_wr, i_start_wr, i_stop_wr, i_latch_wr} = 6'h20 >> k;
        step();
        {i_data_wr, i_data_rd, i_clr_wr, i_start_wr, i_stop_wr, i_latch_wr} = 6'h00;
        step(2);
    endtask
    task automatic frame(input logic [7:0] b);
        int n;
        // Clear the slave before the frame so no line edge meets the clear
        s_clr = 1;
        i_wdata = b;
        step();
        s_clr = 0;
        strobe(0);
        for (n = 0; n < 3000 && o_status[sier_pkg::ST_BUSY] !== 1'b0; n++) step();
        chk("frame busy", 8'h00, o_status & 8'h40);
        step(3);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("rdata", 8'h00, o_rdata);
        chk("status", 8'h00, o_status);
        chk("enable", 8'h00, o_enable_status);
        chk("oe", 8'hff, o_scl_oe_n & o_sda_oe_n);
    endtask
    task automatic t_enable();
        {i_unit_sel, i_chan_mask} = 5'h1a;
        strobe(3);
        chk("enable", 8'ha0, o_enable_status);
        {i_unit_sel, i_chan_mask} = 5'h0f;
        strobe(3);
        chk("enable", 8'haf, o_enable_status);
        {i_unit_sel, i_chan_mask} = 5'h12;
        strobe(4);
        chk("enable", 8'h8f, o_enable_status);
        {i_start_wr, i_stop_wr} = 2'b11;
        step();
        {i_start_wr, i_stop_wr} = 2'b00;
        step(2);
        chk("enable", 8'haf, o_enable_status);
        {i_unit_sel, i_chan_sel} = 3'h4;
        strobe(0);
        chk("busy", 8'h00, o_status & 8'h40);
    endtask
    task automatic t_nack();
        int i;
        logic [1:0] seq [5] = '{2'b00, 2'b10, 2'b11, 2'b10, 2'b00};
        {i_unit_sel, i_chan_sel, s_ack, s_byte} = 12'h0ff;
        frame(8'ha5);
        chk("line byte", 8'ha5, cap[8:1]);
        chk("nack", 8'h02, o_status & 8'h03);
        i_clr_mask = 8'h01;
        strobe(2);
        chk("ack kept", 8'h02, o_status & 8'h02);
        i_clr_mask = o_status;
        strobe(2);
        chk("ack cleared", 8'h00, o_status & 8'h03);
        i_chan_mask = 4'h1;
        strobe(4);
        chk("enable", 8'hae, o_enable_status);
        for (i = 0; i < 5; i++) begin
            {i_cko, i_so} = {3'h7, seq[i][1], 3'h7, seq[i][0]};
            strobe(5);
            chk("lines", {6'h00, seq[i]}, {6'h00, scl_w[0], sda_w[0]});
        end
        strobe(3);
        chk("enable", 8'haf, o_enable_status);
        {i_cko, i_so} = 8'hff;
        strobe(5);
        chk("lines held", 8'h00, {6'h00, scl_w[0], sda_w[0]});
        s_ack = 1;
        frame(8'h3c);
        chk("line byte", 8'h3c, cap[8:1]);
        chk("ack ok", 8'h00, o_status & 8'h03);
    endtask
    task automatic t_rx();
        {i_rx_mode, i_out_en, s_ack, s_byte} = {8'h01, 8'h01, 1'b0, 8'h96};
        frame(8'hff);
        chk("full", 8'h20, o_status & 8'h21);
        chk("master ack", 8'h00, {7'h00, cap[0]});
        {i_out_en, s_byte} = 16'h0069;
        frame(8'hff);
        chk("overrun", 8'h21, o_status & 8'h21);
        chk("last nack", 8'h01, {7'h00, cap[0]});
        strobe(1);
        chk("rdata", 8'h69, o_rdata);
        chk("full", 8'h00, o_status & 8'h20);
        i_clr_mask = o_status;
        strobe(2);
        chk("overrun", 8'h00, o_status & 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {i_rst, i_unit_sel, i_data_wr, i_data_rd, i_clr_wr, i_start_wr, i_stop_wr, i_latch_wr} = 8'h80;
        {i_chan_sel, i_chan_mask, i_cko, i_so, i_wdata, i_clr_mask, i_rx_mode, i_out_en} = 46'h0;
        {s_byte, s_clr, s_ack} = 10'h3fe;
        n_mismatch = 0;
        total_checks = 0;
        repeat (5) @(posedge i_core_clk);
        #1 i_rst = 0;
        step();
        t_reset();
        t_enable();
        t_nack();
        t_rx();
        final_report();
    end
    initial begin
        #(20000 * 100);
        n_mismatch++;
        final_report();
    end
endmodule
